// *** rtl/cpu_bus_defines.svh ***
// Constants for the processor bus-control and interrupt-entry block.
// Assumes a single 25 MHz clock and inputs synchronous to it.
//
// Contract
// - Sixteen address lines on three-state drivers, open when switched off.
// - Eight-line bidirectional data bus with three-state output buffers.
// - Halt low stops at instruction end: bus-available high, valid low.
// - Bus float: address and read/write off within 700 ns, valid low.
// - Read/write high means read, low means write; idles at read.
// - Read/write is off while bus float is high or while halted.
// - Address-valid is active high, never off, marks a valid address.
// - Data drivers enabled only with data-drive-enable high, off on reads.
// - Bus-available low when running or floated, high when halted or waiting.
// - Wait state left only on NMI or unmasked maskable interrupt.
// - Maskable request is a level, sampled at instruction end, mask gated.
// - Interrupt entry pushes index, program counter, accumulators, codes.
// - Maskable entry sets the interrupt mask after stacking.
// - Maskable handler address is fetched from FFF8 and FFF9.
// - NMI edges are latched while halted and served after halt rises; the maskable request is not latched.
// - NMI falling edge stacks state and vectors through FFFC and FFFD.
// - Restart sets the mask and loads the counter from FFFE, FFFF.
// - Interrupt mask is bit 4 of the condition code register.
`ifndef CPU_BUS_DEFINES_SVH
`define CPU_BUS_DEFINES_SVH

`define ADDR_W 16
`define DATA_W 8
`define MASK_BIT 4
`define VEC_IRQ 16'hfff8
`define VEC_NMI 16'hfffc
`define VEC_RST 16'hfffe
`define STACK_LAST 3'h6
`define STACK_FIRST 3'h0
`define CLK_NS 40
`define FLOAT_NS 700
`define FLOAT_CYC ((`FLOAT_NS) / (`CLK_NS))

`endif

// *** rtl/cpu_bus_pkg.sv ***
// Types shared by the bus-control block and its testbench.
// Assumes the constants header is included by each user.
`default_nettype none

package cpu_bus_pkg;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    S_RUN = 7'h01,
    S_HALT = 7'h02,
    S_STACK = 7'h04,
    S_WAIT = 7'h08,
    S_VEC_HI = 7'h10,
    S_VEC_LO = 7'h20,
    S_VEC_END = 7'h40
  } state_t;

  // Why the entry sequence is running
  typedef enum logic [1:0] {
    K_RST = 2'h0,
    K_NMI = 2'h1,
    K_IRQ = 2'h2,
    K_WAIT = 2'h3
  } kind_t;

  // Bus cycle request from the execution core
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } core_bus_t;

  // Programmer registers offered for stacking
  typedef struct packed {
    logic [15:0] ix;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] acca;
    logic [7:0] accb;
    logic [7:0] ccr;
  } cpu_regs_t;

endpackage

`default_nettype wire

// *** rtl/intr_latch.sv ***
// Interrupt request latch: NMI falling-edge catch and IRQ level sample.
// Assumes request pins are synchronous to clock_i.
`default_nettype none

module intr_latch (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic irq_n_i,
  input wire logic nmi_n_i,
  input wire logic nmi_take_i,
  output logic irq_req_o,
  output logic nmi_pend_o
);

  logic nmi_prev_q, nmi_prev_d;
  logic nmi_pend_q, nmi_pend_d;
  logic irq_q, irq_d;

  // Edge detect and sticky pending; a new edge beats the take
  always_comb begin
    nmi_prev_d = nmi_n_i;
    irq_d = ~irq_n_i;
    nmi_pend_d = nmi_pend_q;
    if (nmi_take_i) begin
      nmi_pend_d = 1'b0;
    end
    if (nmi_prev_q && !nmi_n_i) begin
      nmi_pend_d = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_prev_d;
      nmi_pend_q <= nmi_pend_d;
      irq_q <= irq_d;
    end
  end

  assign irq_req_o = irq_q;
  assign nmi_pend_o = nmi_pend_q;

endmodule

`default_nettype wire

// *** rtl/cpu_bus_control.sv ***
// Bus control and interrupt entry sequencer of an 8-bit processor.
// Assumes a core that flags instruction ends and offers its registers.
`default_nettype none
`include "cpu_bus_defines.svh"

module cpu_bus_control #(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic halt_n_i,
  input wire logic bus_float_control_i,
  input wire logic data_drive_enable_i,
  input wire logic irq_n_i,
  input wire logic nmi_n_i,
  input wire logic instr_end_i,
  input wire logic wait_exec_i,
  input wire cpu_bus_pkg::core_bus_t core_bus_i,
  input wire cpu_bus_pkg::cpu_regs_t regs_i,
  input wire logic [DATA_W-1:0] data_lines_i,
  output logic [ADDR_W-1:0] address_lines_o,
  output logic address_oe_n_o,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_oe_n_o,
  output logic read_write_o,
  output logic read_write_oe_n_o,
  output logic address_valid_o,
  output logic bus_available_o,
  output logic seq_busy_o,
  output logic pc_load_o,
  output logic [ADDR_W-1:0] pc_value_o,
  output logic [ADDR_W-1:0] sp_value_o,
  output logic mask_o,
  output logic [DATA_W-1:0] rdata_o
);

  // ****************************************************************
  // Stack frame byte selection
  // ****************************************************************

  // Push order: counter low, high, index low, high, B, A, codes
  function automatic logic [7:0] frame_byte(input logic [2:0] idx,
                                            input cpu_bus_pkg::cpu_regs_t r);
    logic [7:0] b;
    b = r.ccr;
    unique case (idx)
      3'h0: b = r.pc[7:0];
      3'h1: b = r.pc[15:8];
      3'h2: b = r.ix[7:0];
      3'h3: b = r.ix[15:8];
      3'h4: b = r.accb;
      3'h5: b = r.acca;
      default: b = r.ccr;
    endcase
    return b;
  endfunction

  // ****************************************************************
  // Interrupt request latch
  // ****************************************************************

  logic irq_req, nmi_pend, nmi_take;

  intr_latch u_latch (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .irq_n_i(irq_n_i),
    .nmi_n_i(nmi_n_i),
    .nmi_take_i(nmi_take),
    .irq_req_o(irq_req),
    .nmi_pend_o(nmi_pend)
  );

  // ****************************************************************
  // Entry sequencer
  // ****************************************************************

  cpu_bus_pkg::state_t state_q, state_d;
  cpu_bus_pkg::kind_t kind_q, kind_d;
  logic [2:0] cnt_q, cnt_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] vec_q, vec_d;
  logic [7:0] pc_hi_q, pc_hi_d;
  logic mask_q, mask_d;
  logic irq_ok;

  assign irq_ok = irq_req && !mask_q;

  // Next state; a floated bus freezes the sequence in place
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    sp_d = sp_q;
    vec_d = vec_q;
    pc_hi_d = pc_hi_q;
    mask_d = mask_q;
    nmi_take = 1'b0;
    if (!bus_float_control_i) begin
      unique case (state_q)
        cpu_bus_pkg::S_RUN: begin
          if (instr_end_i) begin
            mask_d = regs_i.ccr[`MASK_BIT];
            sp_d = regs_i.sp;
            cnt_d = `STACK_FIRST;
            if (!halt_n_i) begin
              state_d = cpu_bus_pkg::S_HALT;
            end else if (nmi_pend) begin
              state_d = cpu_bus_pkg::S_STACK;
              kind_d = cpu_bus_pkg::K_NMI;
              nmi_take = 1'b1;
            end else if (irq_req && !regs_i.ccr[`MASK_BIT]) begin
              state_d = cpu_bus_pkg::S_STACK;
              kind_d = cpu_bus_pkg::K_IRQ;
            end else if (wait_exec_i) begin
              state_d = cpu_bus_pkg::S_STACK;
              kind_d = cpu_bus_pkg::K_WAIT;
            end
          end
        end
        cpu_bus_pkg::S_HALT: begin
          if (halt_n_i) begin
            state_d = cpu_bus_pkg::S_RUN;
          end
        end
        cpu_bus_pkg::S_STACK: begin
          sp_d = sp_q - 16'h0001;
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == `STACK_LAST) begin
            if (kind_q == cpu_bus_pkg::K_WAIT) begin
              state_d = cpu_bus_pkg::S_WAIT;
            end else begin
              state_d = cpu_bus_pkg::S_VEC_HI;
              vec_d = (kind_q == cpu_bus_pkg::K_NMI) ? `VEC_NMI : `VEC_IRQ;
              if (kind_q == cpu_bus_pkg::K_IRQ) begin
                mask_d = 1'b1;
              end
            end
          end
        end
        cpu_bus_pkg::S_WAIT: begin
          if (nmi_pend) begin
            state_d = cpu_bus_pkg::S_VEC_HI;
            kind_d = cpu_bus_pkg::K_NMI;
            vec_d = `VEC_NMI;
            nmi_take = 1'b1;
          end else if (irq_ok) begin
            state_d = cpu_bus_pkg::S_VEC_HI;
            kind_d = cpu_bus_pkg::K_IRQ;
            vec_d = `VEC_IRQ;
            mask_d = 1'b1;
          end
        end
        cpu_bus_pkg::S_VEC_HI: begin
          state_d = cpu_bus_pkg::S_VEC_LO;
        end
        cpu_bus_pkg::S_VEC_LO: begin
          state_d = cpu_bus_pkg::S_VEC_END;
          pc_hi_d = data_lines_i;
        end
        cpu_bus_pkg::S_VEC_END: begin
          state_d = cpu_bus_pkg::S_RUN;
        end
        default: begin
          state_d = cpu_bus_pkg::S_RUN;
        end
      endcase
    end
  end

  // Sequencer registers; reset enters the restart fetch masked
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_q <= cpu_bus_pkg::S_VEC_HI;
      kind_q <= cpu_bus_pkg::K_RST;
      cnt_q <= `STACK_FIRST;
      sp_q <= 16'h0000;
      vec_q <= `VEC_RST;
      pc_hi_q <= 8'h00;
      mask_q <= 1'b1;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      sp_q <= sp_d;
      vec_q <= vec_d;
      pc_hi_q <= pc_hi_d;
      mask_q <= mask_d;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************

  logic [15:0] addr_d;
  logic [7:0] wdata_d, rdata_d, pc_lo_d;
  logic addr_oe_n_d, data_oe_n_d, rw_d, rw_oe_n_d, valid_d, ba_d;
  logic load_d, seq_write;

  // Bus cycle of the current state, halt and wait in the default branch, then the float override
  always_comb begin
    addr_d = core_bus_i.addr;
    wdata_d = core_bus_i.wdata;
    valid_d = core_bus_i.valid;
    seq_write = core_bus_i.valid && core_bus_i.write;
    ba_d = 1'b0;
    addr_oe_n_d = 1'b0;
    rw_oe_n_d = 1'b0;
    load_d = 1'b0;
    rdata_d = rdata_o;
    pc_lo_d = pc_value_o[7:0];
    unique case (state_q)
      cpu_bus_pkg::S_RUN: begin
        rdata_d = data_lines_i;
      end
      cpu_bus_pkg::S_STACK: begin
        addr_d = sp_q;
        wdata_d = frame_byte(cnt_q, regs_i);
        valid_d = 1'b1;
        seq_write = 1'b1;
      end
      cpu_bus_pkg::S_VEC_HI: begin
        addr_d = vec_q;
        valid_d = 1'b1;
        seq_write = 1'b0;
      end
      cpu_bus_pkg::S_VEC_LO: begin
        addr_d = vec_q + 16'h0001;
        valid_d = 1'b1;
        seq_write = 1'b0;
      end
      cpu_bus_pkg::S_VEC_END: begin
        valid_d = 1'b0;
        seq_write = 1'b0;
        pc_lo_d = data_lines_i;
        load_d = !bus_float_control_i;
      end
      default: begin
        // Halted or waiting: drivers off, bus handed over
        valid_d = 1'b0;
        seq_write = 1'b0;
        ba_d = 1'b1;
        addr_oe_n_d = 1'b1;
        rw_oe_n_d = 1'b1;
      end
    endcase
    rw_d = !seq_write;
    data_oe_n_d = !(seq_write && data_drive_enable_i);
    if (bus_float_control_i) begin
      addr_oe_n_d = 1'b1;
      rw_oe_n_d = 1'b1;
      valid_d = 1'b0;
      ba_d = 1'b0;
    end
  end

  // Output registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      address_lines_o <= 16'h0000;
      address_oe_n_o <= 1'b1;
      data_lines_o <= 8'h00;
      data_oe_n_o <= 1'b1;
      read_write_o <= 1'b1;
      read_write_oe_n_o <= 1'b1;
      address_valid_o <= 1'b0;
      bus_available_o <= 1'b0;
      seq_busy_o <= 1'b1;
      pc_load_o <= 1'b0;
      pc_value_o <= 16'h0000;
      sp_value_o <= 16'h0000;
      mask_o <= 1'b1;
      rdata_o <= 8'h00;
    end else begin
      address_lines_o <= addr_d;
      address_oe_n_o <= addr_oe_n_d;
      data_lines_o <= wdata_d;
      data_oe_n_o <= data_oe_n_d;
      read_write_o <= rw_d;
      read_write_oe_n_o <= rw_oe_n_d;
      address_valid_o <= valid_d;
      bus_available_o <= ba_d;
      seq_busy_o <= (state_d != cpu_bus_pkg::S_RUN) || bus_float_control_i;
      pc_load_o <= load_d;
      pc_value_o <= {pc_hi_q, pc_lo_d};
      sp_value_o <= sp_q;
      mask_o <= mask_q;
      rdata_o <= rdata_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  float_off_a: assert property (
    bus_float_control_i |=> address_oe_n_o && read_write_oe_n_o
      && !address_valid_o && !bus_available_o)
    else $error("bus float did not release the bus");

  halt_bus_a: assert property (
    state_q == cpu_bus_pkg::S_HALT && !bus_float_control_i
      |=> bus_available_o && !address_valid_o && address_oe_n_o
        && data_oe_n_o && read_write_oe_n_o)
    else $error("halted bus not handed over");

  data_drive_a: assert property (
    !data_oe_n_o |-> $past(data_drive_enable_i) && !read_write_o)
    else $error("data drivers on without enable or during read");

  rw_idle_a: assert property (
    !address_valid_o && !read_write_oe_n_o |-> read_write_o)
    else $error("read/write not idling at read");

  wait_hold_a: assert property (
    state_q == cpu_bus_pkg::S_WAIT && !nmi_pend && !irq_ok
      |=> state_q == cpu_bus_pkg::S_WAIT)
    else $error("wait left without interrupt");

  irq_mask_a: assert property (
    state_q == cpu_bus_pkg::S_STACK && cnt_q == `STACK_LAST
      && kind_q == cpu_bus_pkg::K_IRQ && !bus_float_control_i
      |=> mask_q ##1 address_lines_o == `VEC_IRQ)
    else $error("maskable entry missed mask or vector");

  stack_len_a: assert property (
    $rose(state_q == cpu_bus_pkg::S_STACK) && !bus_float_control_i
      ##1 !bus_float_control_i [*6] |=> state_q != cpu_bus_pkg::S_STACK)
    else $error("stack frame not seven bytes");

  vec_order_a: assert property (
    pc_load_o && !$past(bus_float_control_i, 2)
      |-> pc_value_o[7:0] == $past(data_lines_i)
      && pc_value_o[15:8] == $past(data_lines_i, 2))
    else $error("vector bytes paired wrongly");

  halt_latch_a: assert property (
    state_q == cpu_bus_pkg::S_HALT && !halt_n_i
      |=> state_q == cpu_bus_pkg::S_HALT)
    else $error("interrupt served while halted");

  irq_entry_c: cover property (
    state_q == cpu_bus_pkg::S_VEC_HI && kind_q == cpu_bus_pkg::K_IRQ);
  nmi_entry_c: cover property (
    state_q == cpu_bus_pkg::S_VEC_HI && kind_q == cpu_bus_pkg::K_NMI);
  wait_exit_c: cover property (
    state_q == cpu_bus_pkg::S_WAIT ##1 state_q == cpu_bus_pkg::S_VEC_HI);
  halt_c: cover property (state_q == cpu_bus_pkg::S_HALT ##1 halt_n_i);

endmodule

`default_nettype wire

// *** tb/bus_memory.sv ***
// Memory and peripheral model on the far side of the processor bus.
// Assumes registered bus pins from the block and one shared clock.
`default_nettype none

module bus_memory (
  input wire logic clock_i,
  input wire logic [15:0] address_lines_i,
  input wire logic address_oe_n_i,
  input wire logic [7:0] data_lines_i,
  input wire logic data_oe_n_i,
  input wire logic read_write_i,
  input wire logic address_valid_i,
  output logic [7:0] data_lines_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [15:0] rd_a [$];
  logic [15:0] wr_a [$];
  logic [7:0] wr_d [$];
  logic [7:0] last_q = 8'h00;
  logic rd;
  logic wr;
  int bad_drive = 0;

  // Answer reads; an idle bus shows a pattern that flips every cycle
  assign rd = address_valid_i && read_write_i && !address_oe_n_i;
  assign wr = address_valid_i && !read_write_i && !address_oe_n_i;
  assign data_lines_o = rd ? mem[address_lines_i] : ~last_q;

  // Log reads and the writes that the block really drives, and store those writes
  always @(posedge clock_i) begin
    last_q <= data_lines_o;
    if (rd) begin
      rd_a.push_back(address_lines_i);
      if (!data_oe_n_i) bad_drive++;
    end
    if (wr && !data_oe_n_i) begin
      wr_a.push_back(address_lines_i);
      wr_d.push_back(data_lines_i);
      mem[address_lines_i] = data_lines_i;
    end
  end
endmodule

`default_nettype wire

// *** tb/tb_cpu_bus_control.sv ***
// Self-checking bench for the bus control and interrupt entry block.
// Assumes the package, the defines header and the memory model.
`default_nettype none

module tb_cpu_bus_control;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals
  // ****************************************
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic halt_n = 1'b1, flt = 1'b0, dde = 1'b1, irq_n = 1'b1;
  logic nmi_n = 1'b1, iend = 1'b0, wexec = 1'b0;
  cpu_bus_pkg::core_bus_t core = '0;
  cpu_bus_pkg::cpu_regs_t regs = '{16'h1234, 16'h5678, 16'h01ff,
    8'haa, 8'hbb, 8'hd0};
  logic [7:0] din, dout, rdata;
  logic [15:0] addr, pcv, spv;
  logic aoe_n, doe_n, rw, rwoe_n, valid, avail, busy, pcl, mask;
  int fail_count = 0;
  int tests_run = 0;

  always #20 clock_i = ~clock_i;

  cpu_bus_control cpu_bus_control_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .halt_n_i(halt_n), .bus_float_control_i(flt),
    .data_drive_enable_i(dde), .irq_n_i(irq_n), .nmi_n_i(nmi_n),
    .instr_end_i(iend), .wait_exec_i(wexec), .core_bus_i(core),
    .regs_i(regs), .data_lines_i(din), .address_lines_o(addr),
    .address_oe_n_o(aoe_n), .data_lines_o(dout), .data_oe_n_o(doe_n),
    .read_write_o(rw), .read_write_oe_n_o(rwoe_n),
    .address_valid_o(valid), .bus_available_o(avail), .seq_busy_o(busy),
    .pc_load_o(pcl), .pc_value_o(pcv), .sp_value_o(spv), .mask_o(mask),
    .rdata_o(rdata));

  bus_memory bus_memory_i (.clock_i(clock_i), .address_lines_i(addr),
    .address_oe_n_i(aoe_n), .data_lines_i(dout), .data_oe_n_i(doe_n),
    .read_write_i(rw), .address_valid_i(valid), .data_lines_o(din));

  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic clr();
    bus_memory_i.rd_a.delete();
    bus_memory_i.wr_a.delete();
    bus_memory_i.wr_d.delete();
  endtask

  // One-cycle instruction end pulse from the core
  task automatic end_instr(input logic w);
    @(negedge clock_i);
    iend = 1'b1;
    wexec = w;
    @(negedge clock_i);
    iend = 1'b0;
    wexec = 1'b0;
  endtask

  // Bounded wait for the handler address pulse
  task automatic wait_load();
    int n;
    n = 0;
    while (pcl !== 1'b1 && n < 60) begin
      @(negedge clock_i);
      n++;
    end
    check("load pulse", 16'(n < 60), 16'h1);
  endtask

  // Stacked bytes, stack addresses and vector pair of one entry
  task automatic check_entry(input logic [15:0] vec);
    logic [7:0] exp_d [7];
    exp_d = '{regs.pc[7:0], regs.pc[15:8], regs.ix[7:0], regs.ix[15:8],
      regs.accb, regs.acca, regs.ccr};
    wait_load();
    check("stack count", 16'(bus_memory_i.wr_a.size()), 16'h7);
    for (int k = 0; k < 7; k++) begin
      check("stack addr", bus_memory_i.wr_a[k], regs.sp - 16'(k));
      check("stack data", 16'(bus_memory_i.wr_d[k]), 16'(exp_d[k]));
    end
    check("vector hi", bus_memory_i.rd_a[0], vec);
    check("vector lo", bus_memory_i.rd_a[1], vec + 16'h1);
    check("handler", pcv, {pat(vec), pat(vec + 16'h1)});
    check("stack ptr", spv, regs.sp - 16'h7);
    check("mask set", 16'(mask), 16'h1);
    repeat (3) @(negedge clock_i);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_restart();
    wait_load();
    check("restart hi", bus_memory_i.rd_a[0], 16'hfffe);
    check("restart lo", bus_memory_i.rd_a[1], 16'hffff);
    check("restart pc", pcv, {pat(16'hfffe), pat(16'hffff)});
    check("restart mask", 16'(mask), 16'h1);
    repeat (3) @(negedge clock_i);
    $display("restart done");
  endtask

  task automatic t_bus();
    clr();
    core = '{1'b1, 1'b1, 16'h0300, 8'h5a};
    @(negedge clock_i);
    check("write drive", 16'(doe_n), 16'h0);
    check("write rw", 16'(rw), 16'h0);
    core = '{1'b1, 1'b0, 16'h0301, 8'h00};
    @(negedge clock_i);
    check("read rw", 16'(rw), 16'h1);
    core = '0;
    @(negedge clock_i);
    check("read data", 16'(rdata), 16'(pat(16'h0301)));
    repeat (2) @(negedge clock_i);
    check("write addr", bus_memory_i.wr_a[0], 16'h0300);
    check("write data", 16'(bus_memory_i.wr_d[0]), 16'h5a);
    check("read addr", bus_memory_i.rd_a[0], 16'h0301);
    check("read drive", 16'(bus_memory_i.bad_drive), 16'h0);
    check("idle rw", 16'(rw), 16'h1);
    check("idle valid", 16'(valid), 16'h0);
    dde = 1'b0;
    core = '{1'b1, 1'b1, 16'h0302, 8'h66};
    repeat (2) @(negedge clock_i);
    check("data off", 16'(doe_n), 16'h1);
    check("dma valid", 16'(valid), 16'h1);
    core = '0;
    dde = 1'b1;
    @(negedge clock_i);
    check("no store", 16'(bus_memory_i.wr_a.size()), 16'h1);
    $display("bus cycles done");
  endtask

  task automatic t_irq(input logic masked);
    clr();
    regs.ccr = masked ? 8'hd0 : 8'hc0;
    irq_n = 1'b0;
    end_instr(1'b0);
    if (masked) begin
      repeat (15) @(negedge clock_i);
      check("no entry", 16'(bus_memory_i.wr_a.size()), 16'h0);
      check("not busy", 16'(busy), 16'h0);
    end else begin
      check_entry(16'hfff8);
    end
    irq_n = 1'b1;
    regs.ccr = 8'hd0;
    $display("irq test done");
  endtask

  task automatic t_nmi();
    clr();
    @(negedge clock_i);
    nmi_n = 1'b0;
    end_instr(1'b0);
    check_entry(16'hfffc);
    nmi_n = 1'b1;
    $display("nmi test done");
  endtask

  task automatic t_halt();
    halt_n = 1'b0;
    end_instr(1'b0);
    repeat (3) @(negedge clock_i);
    check("halt avail", 16'(avail), 16'h1);
    check("halt valid", 16'(valid), 16'h0);
    check("halt addr off", 16'(aoe_n), 16'h1);
    check("halt rw off", 16'(rwoe_n), 16'h1);
    check("halt data off", 16'(doe_n), 16'h1);
    clr();
    nmi_n = 1'b0;
    repeat (10) @(negedge clock_i);
    check("held nmi", 16'(bus_memory_i.wr_a.size()), 16'h0);
    halt_n = 1'b1;
    @(negedge clock_i);
    halt_n = 1'b0;
    @(negedge clock_i);
    check("step run", 16'(avail), 16'h0);
    end_instr(1'b0);
    repeat (2) @(negedge clock_i);
    check("step halt", 16'(avail), 16'h1);
    check("step held", 16'(bus_memory_i.wr_a.size()), 16'h0);
    halt_n = 1'b1;
    nmi_n = 1'b1;
    repeat (2) @(negedge clock_i);
    check("run avail", 16'(avail), 16'h0);
    end_instr(1'b0);
    check_entry(16'hfffc);
    $display("halt test done");
  endtask

  task automatic t_wait();
    clr();
    regs.ccr = 8'hc0;
    end_instr(1'b1);
    repeat (14) @(negedge clock_i);
    check("wait avail", 16'(avail), 16'h1);
    check("wait stays", 16'(bus_memory_i.rd_a.size()), 16'h0);
    irq_n = 1'b0;
    check_entry(16'hfff8);
    irq_n = 1'b1;
    regs.ccr = 8'hd0;
    $display("wait test done");
  endtask

  task automatic t_float();
    int n;
    n = 0;
    core = '{1'b1, 1'b1, 16'h0304, 8'ha5};
    @(negedge clock_i);
    flt = 1'b1;
    while (aoe_n !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    check("float time", 16'(n <= 17), 16'h1);
    check("float rw", 16'(rwoe_n), 16'h1);
    check("float valid", 16'(valid), 16'h0);
    check("float avail", 16'(avail), 16'h0);
    check("float data", 16'(doe_n), 16'h0);
    repeat (5) @(negedge clock_i);
    flt = 1'b0;
    core = '0;
    repeat (2) @(negedge clock_i);
    $display("float test done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well above the sum of all scenarios
  initial begin
    repeat (3000) @(posedge clock_i);
    fail_count++;
    $display("[ERR] watchdog expected finish seen hang");
    complete_run();
  end

  // Main sequence
  initial begin
    for (int i = 0; i < 65536; i++) bus_memory_i.mem[i] = pat(i[15:0]);
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_restart();
    t_bus();
    t_irq(1'b0);
    t_irq(1'b1);
    t_nmi();
    t_halt();
    t_wait();
    t_float();
    complete_run();
  end
endmodule

`default_nettype wire
